// ---- rtl/uart_core.sv ----
// Serial port data path: mode register, receive and transmit buffers.
// Assumes the CPU port is synchronous to clk_in and that base_fall_in
// pulses for one cycle at each falling edge of the selected base clock.
//
// Notes on behaviour
// - Each finished character moves from the shift stage into the buffer unless it overruns.
// - Seven-bit LSB-first characters fill bits 0..6; bit 7 reads zero.
// - Seven-bit MSB-first characters fill bits 7..1; bit 0 reads zero.
// - On overrun the receive buffer keeps its old value.
// - Receive buffer is read-only and resets to all ones.
// - The receive shift stage parallelises the serial input, hidden.
// - Writing the transmit buffer starts sending; read/write, resets to ones.
// - First frame: buffer goes to the shifter at the first base clock falling edge after the write.
// - Back to back: next value loads just before the completion pulse.
// - Transfers and output bits happen on base clock falling edges.
// - Mode register takes bit and byte writes, resets to one.
// - Rewriting the mode register unchanged leaves traffic undisturbed.
// - Mode register field layout; clearing transmit enable resets transmit.
// - Clearing power enable stops and resets the internal circuit.
// - Clearing receive enable resets the receiver; setting enables it.
// - Parity select: none, zero, odd or even, both directions.
// - Length bit: clear gives seven bits, set gives eight.
`timescale 1ns/10ps
`default_nettype none
module uart_core #(
  parameter int OVS = uart_pkg::OVS_DEF
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        base_fall_in,
  input  wire logic        msb_first_in,
  input  wire logic        tx_invert_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_bit_wr_in,
  input  wire logic [2:0]  cpu_bit_idx_in,
  input  wire logic        cpu_bit_val_in,
  input  wire logic [7:0]  cpu_wdata_in,
  input  wire logic        cpu_rd_in,
  input  wire logic        serial_in_pin_in,
  output logic [7:0]       cpu_rdata_out,
  output logic             serial_out_pin_out,
  output logic             transmit_complete_irq_out,
  output logic             rx_done_irq_out,
  output logic             rx_error_irq_out
);
  localparam int CW = $clog2(OVS);
  localparam logic [CW-1:0] FULL = CW'(OVS - 1);

  initial
  begin
    if (OVS < 4 || OVS > 256)
      $error("OVS must lie between 4 and 256");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]     serial_operation_mode_r;
  logic [7:0]     receive_buffer_r;
  logic [7:0]     transmit_buffer_r;
  logic           rx_unread_r;
  logic           overrun_flag_r;
  logic           parity_err_r;
  logic           framing_err_r;
  logic           tx_buffer_full_flag_r;
  logic           tx_active_r;
  logic [11:0]    tx_frame_r;
  logic [3:0]     tx_left_r;
  logic [CW-1:0]  tx_cnt_r;
  logic           tx_line_r;
  logic           irq_pend_r;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        power_enable;
  logic        transmit_enable;
  logic        receive_enable;
  logic [1:0]  parity_sel;
  logic        char_length_sel;
  logic        stop_bit_count_sel;
  logic        error_interrupt_routing;
  logic        tx_run;
  logic        rx_run;
  logic        sel_mode;
  logic        sel_err;
  logic        sel_txst;
  logic        sel_rxbuf;
  logic        sel_txbuf;
  logic        wr_txbuf;
  logic        rd_rxbuf;
  logic        rd_err;
  logic [7:0]  mode_nxt;
  logic [7:0]  rdata_nxt;
  logic [7:0]  err_status;
  logic [7:0]  tx_status;

  assign power_enable            = serial_operation_mode_r[uart_pkg::POWER_BIT];
  assign transmit_enable         = serial_operation_mode_r[uart_pkg::TXE_BIT];
  assign receive_enable          = serial_operation_mode_r[uart_pkg::RXE_BIT];
  assign parity_sel              = serial_operation_mode_r[uart_pkg::PS_HI_BIT:
                                                          uart_pkg::PS_LO_BIT];
  assign char_length_sel         = serial_operation_mode_r[uart_pkg::CL_BIT];
  assign stop_bit_count_sel      = serial_operation_mode_r[uart_pkg::SL_BIT];
  assign error_interrupt_routing = serial_operation_mode_r[uart_pkg::ISRM_BIT];
  // Power gates both engines; the enables are plain levels, so rewriting
  // the same mode value changes nothing downstream
  assign tx_run = power_enable & transmit_enable;
  assign rx_run = power_enable & receive_enable;

  assign sel_mode  = (cpu_addr_in == uart_pkg::MODE_OFS);
  assign sel_err   = (cpu_addr_in == uart_pkg::ERR_OFS);
  assign sel_txst  = (cpu_addr_in == uart_pkg::TXST_OFS);
  assign sel_rxbuf = (cpu_addr_in == uart_pkg::RXBUF_OFS);
  assign sel_txbuf = (cpu_addr_in == uart_pkg::TXBUF_OFS);
  assign wr_txbuf  = cpu_wr_in & sel_txbuf;
  assign rd_rxbuf  = cpu_rd_in & sel_rxbuf;
  assign rd_err    = cpu_rd_in & sel_err;

  // Byte write or single-bit write of the mode register
  always_comb
  begin
    mode_nxt = serial_operation_mode_r;
    if (cpu_wr_in && sel_mode)
      mode_nxt = cpu_wdata_in;
    else if (cpu_bit_wr_in && sel_mode)
      mode_nxt[cpu_bit_idx_in] = cpu_bit_val_in;
  end

  assign err_status = {5'h00, parity_err_r, framing_err_r, overrun_flag_r};
  assign tx_status  = {6'h00, tx_buffer_full_flag_r, tx_active_r};
  assign rdata_nxt  = sel_mode  ? serial_operation_mode_r :
                      sel_err   ? err_status :
                      sel_txst  ? tx_status :
                      sel_rxbuf ? receive_buffer_r :
                      sel_txbuf ? transmit_buffer_r : uart_pkg::ZERO_BYTE;

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_ferr;
  logic        overrun;
  logic        rx_any_err;

  rx_shifter #(
    .OVS (OVS)
  ) u_rx (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .ce_in            (ce_in),
    .run_in           (rx_run),
    .tick_in          (base_fall_in),
    .serial_in_pin_in (serial_in_pin_in),
    .char8_in         (char_length_sel),
    .msb_first_in     (msb_first_in),
    .parity_sel_in    (parity_sel),
    .done_out         (rx_done),
    .data_out         (rx_data),
    .parity_err_out   (rx_perr),
    .framing_err_out  (rx_ferr)
  );

  // A read in the same cycle empties the buffer in time for the new byte
  assign overrun    = rx_done & rx_unread_r & ~rd_rxbuf;
  assign rx_any_err = overrun | rx_perr | rx_ferr;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || (ce_in && !power_enable))
    begin
      receive_buffer_r <= uart_pkg::BUF_RST;
      rx_unread_r      <= 1'b0;
      rx_done_irq_out  <= 1'b0;
      rx_error_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // Buffer has no write path from the CPU at all
      if (rx_done && !overrun)
        receive_buffer_r <= rx_data;
      rx_unread_r      <= (rx_done & ~overrun) | (rx_unread_r & ~rd_rxbuf);
      rx_done_irq_out  <= rx_done & (~rx_any_err | error_interrupt_routing);
      rx_error_irq_out <= rx_done & rx_any_err & ~error_interrupt_routing;
    end
  end

  // Error flags: a new error wins over the clearing read
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || (ce_in && !rx_run))
    begin
      overrun_flag_r <= 1'b0;
      parity_err_r   <= 1'b0;
      framing_err_r  <= 1'b0;
    end
    else if (ce_in)
    begin
      overrun_flag_r <= overrun | (overrun_flag_r & ~rd_err);
      parity_err_r   <= (rx_done & rx_perr) | (parity_err_r & ~rd_err);
      framing_err_r  <= (rx_done & rx_ferr) | (framing_err_r & ~rd_err);
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  logic [7:0]  tx_order;
  logic [7:0]  tx_data;
  logic        tx_par;
  logic        tx_par_on;
  logic [11:0] frame_nxt;
  logic [3:0]  left_nxt;
  logic        tx_step;
  logic        bit_end;
  logic        load_now;

  // MSB-first reverses the byte; seven-bit mode then sends bits 7..1
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      assign tx_order[gi] = msb_first_in ? transmit_buffer_r[7 - gi]
                                         : transmit_buffer_r[gi];
    end
  endgenerate

  assign tx_data   = char_length_sel ? tx_order
                                     : {1'b1, tx_order[6:0]};
  assign tx_par    = (parity_sel == uart_pkg::PAR_ZERO) ? 1'b0 :
                     (parity_sel == uart_pkg::PAR_ODD)
                       ? ~(^tx_data[6:0] ^ (char_length_sel & tx_data[7]))
                       : (^tx_data[6:0] ^ (char_length_sel & tx_data[7]));
  assign tx_par_on = (parity_sel != uart_pkg::PAR_NONE);

  // Frame after the start bit, stop bits padded with ones
  always_comb
  begin
    frame_nxt = {12{1'b1}};
    if (char_length_sel)
    begin
      frame_nxt[7:0] = tx_data;
      frame_nxt[8]   = tx_par_on ? tx_par : 1'b1;
    end
    else
    begin
      frame_nxt[6:0] = tx_data[6:0];
      frame_nxt[7]   = tx_par_on ? tx_par : 1'b1;
    end
  end

  // Bits still to go after the start bit: data, parity, stop
  assign left_nxt = 4'(4'h8 + {3'h0, char_length_sel} + {3'h0, tx_par_on}
                    + {3'h0, stop_bit_count_sel});

  assign tx_step  = ce_in & base_fall_in;
  assign bit_end  = tx_active_r & (tx_cnt_r == FULL);
  assign load_now = tx_step & tx_buffer_full_flag_r
                    & (~tx_active_r | (bit_end & (tx_left_r == 4'h0)));

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      transmit_buffer_r <= uart_pkg::BUF_RST;
    else if (ce_in && wr_txbuf)
      transmit_buffer_r <= cpu_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || (ce_in && !tx_run))
    begin
      tx_buffer_full_flag_r <= 1'b0;
      tx_active_r           <= 1'b0;
      tx_frame_r            <= {12{1'b1}};
      tx_left_r             <= 4'h0;
      tx_cnt_r              <= '0;
      tx_line_r             <= 1'b1;
      irq_pend_r            <= 1'b0;
    end
    else if (ce_in)
    begin
      // A write sets the full flag even in the cycle of a transfer
      tx_buffer_full_flag_r <= wr_txbuf | (tx_buffer_full_flag_r & ~load_now);
      irq_pend_r            <= 1'b0;
      if (tx_step && tx_active_r)
        tx_cnt_r <= bit_end ? '0 : CW'(tx_cnt_r + 1'b1);
      if (load_now)
      begin
        tx_frame_r  <= frame_nxt;
        tx_left_r   <= left_nxt;
        tx_cnt_r    <= '0;
        tx_line_r   <= 1'b0;
        tx_active_r <= 1'b1;
        irq_pend_r  <= tx_active_r;
      end
      else if (tx_step && bit_end)
      begin
        if (tx_left_r == 4'h0)
        begin
          tx_active_r <= 1'b0;
          irq_pend_r  <= 1'b1;
        end
        else
        begin
          tx_line_r  <= tx_frame_r[0];
          tx_frame_r <= {1'b1, tx_frame_r[11:1]};
          tx_left_r  <= 4'(tx_left_r - 1'b1);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      serial_operation_mode_r   <= uart_pkg::MODE_RST;
      cpu_rdata_out             <= uart_pkg::ZERO_BYTE;
      serial_out_pin_out        <= 1'b1;
      transmit_complete_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      serial_operation_mode_r   <= mode_nxt;
      cpu_rdata_out             <= cpu_rd_in ? rdata_nxt : cpu_rdata_out;
      // Idle and stopped lines rest high, flipped only by inversion
      serial_out_pin_out        <= (tx_run ? tx_line_r : 1'b1)
                                   ^ tx_invert_in;
      transmit_complete_irq_out <= irq_pend_r;
    end
  end

endmodule : uart_core
`default_nettype wire

// ---- inc/uart_pkg.sv ----
// Package for the serial port data path and mode control.
// Assumes an 8-bit CPU register port with 16-bit addresses.
package uart_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_OFS   = 16'hff50;
  localparam logic [15:0] ERR_OFS    = 16'hff53;
  localparam logic [15:0] TXST_OFS   = 16'hff55;
  localparam logic [15:0] RXBUF_OFS  = 16'hff56;
  localparam logic [15:0] TXBUF_OFS  = 16'hff57;

  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int POWER_BIT  = 7;
  localparam int TXE_BIT    = 6;
  localparam int RXE_BIT    = 5;
  localparam int PS_HI_BIT  = 4;
  localparam int PS_LO_BIT  = 3;
  localparam int CL_BIT     = 2;
  localparam int SL_BIT     = 1;
  localparam int ISRM_BIT   = 0;

  // Status fields
  localparam int TXBF_BIT   = 1;
  localparam int TXSF_BIT   = 0;
  localparam int PE_BIT     = 2;
  localparam int FE_BIT     = 1;
  localparam int OVE_BIT    = 0;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_RST   = 8'h01;
  localparam logic [7:0] BUF_RST    = 8'hff;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_ZERO   = 2'h1;
  localparam logic [1:0] PAR_ODD    = 2'h2;
  localparam logic [1:0] PAR_EVEN   = 2'h3;

  // Base clocks per bit time
  localparam int OVS_DEF = 16;

endpackage : uart_pkg

// ---- rtl/rx_shifter.sv ----
// Receive shift stage: samples the serial input and packs one character.
// Assumes tick_in marks base clock falling edges, OVS of them per bit.
`timescale 1ns/10ps
`default_nettype none
module rx_shifter #(
  parameter int OVS = uart_pkg::OVS_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       run_in,
  input  wire logic       tick_in,
  input  wire logic       serial_in_pin_in,
  input  wire logic       char8_in,
  input  wire logic       msb_first_in,
  input  wire logic [1:0] parity_sel_in,
  output logic            done_out,
  output logic [7:0]      data_out,
  output logic            parity_err_out,
  output logic            framing_err_out
);
  localparam int CW = $clog2(OVS);
  localparam logic [CW-1:0] HALF = CW'(OVS / 2 - 1);
  localparam logic [CW-1:0] FULL = CW'(OVS - 1);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
    rx_state_e;

  rx_state_e       state_r;
  logic [CW-1:0]   cnt_r;
  logic [2:0]      bit_idx_r;
  logic            par_r;
  logic [2:0]      last_idx;
  logic [2:0]      pos;
  logic            at_full;
  logic            par_bad;
  logic            step;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign step     = ce_in & tick_in;
  assign at_full  = (cnt_r == FULL);
  assign last_idx = char8_in ? 3'h7 : 3'h6;
  // 7-bit characters land in 0..6 or 7..1, leaving the other end zero
  assign pos      = msb_first_in ? 3'(3'h7 - bit_idx_r) : bit_idx_r;
  assign par_bad  = (parity_sel_in == uart_pkg::PAR_ODD)
                      ? ~(par_r ^ serial_in_pin_in)
                      : (parity_sel_in == uart_pkg::PAR_EVEN)
                        & (par_r ^ serial_in_pin_in);

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || (ce_in && !run_in))
    begin
      state_r         <= RX_IDLE;
      cnt_r           <= '0;
      bit_idx_r       <= 3'h0;
      par_r           <= 1'b0;
      data_out        <= uart_pkg::BUF_RST;
      done_out        <= 1'b0;
      parity_err_out  <= 1'b0;
      framing_err_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      if (step)
      begin
        cnt_r <= at_full ? '0 : CW'(cnt_r + 1'b1);
        case (state_r)
          RX_IDLE:
          begin
            cnt_r <= '0;
            if (!serial_in_pin_in)
              state_r <= RX_START;
          end
          RX_START:
            if (cnt_r == HALF)
            begin
              cnt_r     <= '0;
              // A glitch shorter than half a bit is no start bit
              state_r   <= serial_in_pin_in ? RX_IDLE : RX_DATA;
              bit_idx_r <= 3'h0;
              par_r     <= 1'b0;
              data_out  <= uart_pkg::ZERO_BYTE;
            end
          RX_DATA:
            if (at_full)
            begin
              data_out[pos] <= serial_in_pin_in;
              par_r         <= par_r ^ serial_in_pin_in;
              bit_idx_r     <= 3'(bit_idx_r + 1'b1);
              if (bit_idx_r == last_idx)
                state_r <= (parity_sel_in == uart_pkg::PAR_NONE)
                             ? RX_STOP : RX_PARITY;
            end
          RX_PARITY:
            if (at_full)
            begin
              parity_err_out <= par_bad;
              state_r        <= RX_STOP;
            end
          RX_STOP:
            if (at_full)
            begin
              // Only the first stop bit is checked
              framing_err_out <= ~serial_in_pin_in;
              done_out        <= 1'b1;
              state_r         <= RX_IDLE;
            end
          default:
            state_r <= RX_IDLE;
        endcase
        if (state_r == RX_START && cnt_r == HALF)
          parity_err_out <= 1'b0;
      end
    end
  end

endmodule : rx_shifter
`default_nettype wire

// ---- tb/uart_core_asserts.sv ----
// Port checker for the serial data path and mode control.
// Assumes it is bound to uart_core with ce_in normally high.
`timescale 1ns/10ps
`default_nettype none
module uart_core_asserts #(
  parameter int OVS = uart_pkg::OVS_DEF
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        base_fall_in,
  input  wire logic        tx_invert_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_bit_wr_in,
  input  wire logic [2:0]  cpu_bit_idx_in,
  input  wire logic        cpu_bit_val_in,
  input  wire logic [7:0]  cpu_wdata_in,
  input  wire logic        cpu_rd_in,
  input  wire logic [7:0]  cpu_rdata_out,
  input  wire logic        serial_out_pin_out,
  input  wire logic        transmit_complete_irq_out,
  input  wire logic        rx_done_irq_out,
  input  wire logic        rx_error_irq_out
);
  // ------
  // Mode-write decodes and port properties
  // ------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic mode_sel = ce_in && cpu_addr_in == uart_pkg::MODE_OFS;
  wire logic bit_clr  = cpu_bit_wr_in && !cpu_bit_val_in;
  // Byte write wins over bit write
  wire logic pwr_off  = mode_sel && (cpu_wr_in ? !cpu_wdata_in[7]
                        : bit_clr && cpu_bit_idx_in == 3'h7);
  wire logic txe_off  = mode_sel && (cpu_wr_in ? !cpu_wdata_in[6]
                        : bit_clr && cpu_bit_idx_in == 3'h6);
  wire logic any_off  = pwr_off || txe_off;
  wire logic idle_lvl = !tx_invert_in;
  wire logic mapped   = cpu_addr_in inside {uart_pkg::MODE_OFS,
    uart_pkg::ERR_OFS, uart_pkg::TXST_OFS, uart_pkg::RXBUF_OFS,
    uart_pkg::TXBUF_OFS};
  property p_idle_rst;
    $rose(rst_n_in) |-> serial_out_pin_out;
  endproperty
  a_idle_rst: assert property (p_idle_rst)
    else $error("Line low after reset");
  // Off-grid edges only where a mode write stops the line
  property p_line_base;
    $changed(serial_out_pin_out) && $past(rst_n_in) && $stable(tx_invert_in)
      && !$past(any_off) && !$past(any_off, 2) && !$past(any_off, 3)
      |-> $past(base_fall_in) || $past(base_fall_in, 2);
  endproperty
  a_line_base: assert property (p_line_base)
    else $error("Line moved off a base edge");
  property p_tc_base;
    transmit_complete_irq_out
      |-> $past(base_fall_in, 2) || $past(base_fall_in, 3);
  endproperty
  a_tc_base: assert property (p_tc_base)
    else $error("Completion pulse off a base edge");
  property p_unmapped;
    cpu_rd_in && ce_in && !mapped |=> cpu_rdata_out == uart_pkg::ZERO_BYTE;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped read not zero");
  property p_rdata_hold;
    $past(rst_n_in) && !$past(cpu_rd_in && ce_in) |-> $stable(cpu_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data moved without a read");
  property p_rx_pulse;
    rx_done_irq_out |-> !rx_error_irq_out ##1 !rx_done_irq_out;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("Receive pulse malformed");
  property p_pwr_idle;
    pwr_off |-> ##[1:3] serial_out_pin_out == idle_lvl;
  endproperty
  a_pwr_idle: assert property (p_pwr_idle)
    else $error("Line not idle after power off");
  property p_txe_idle;
    txe_off |-> ##[1:3] serial_out_pin_out == idle_lvl;
  endproperty
  a_txe_idle: assert property (p_txe_idle)
    else $error("Line not idle after transmit off");
  c_tx_done: cover property (transmit_complete_irq_out);
  c_rx_done: cover property (rx_done_irq_out);
  c_pwr_off: cover property (pwr_off);
endmodule : uart_core_asserts
`default_nettype wire

// ---- tb/remote_node.sv ----
// Remote serial node: frames onto the receive pin, decodes transmit pin.
// Assumes base_fall_in pulses OVS times per bit; no parity, one stop.
`timescale 1ns/10ps
`default_nettype none
module remote_node #(
  parameter int OVS = 4
) (
  input  wire logic clk_in,
  input  wire logic base_fall_in,
  input  wire logic tx_line_in,
  output var logic  rx_line_out
);
  // ------
  // Frame tasks
  // ------
  initial rx_line_out = 1'b1;
  task automatic wait_base(input int n);
    repeat (n) @(posedge clk_in iff base_fall_in);
  endtask : wait_base
  task automatic send(input logic [7:0] d, input int nb, input logic msb);
    wait_base(1);
    #1 rx_line_out = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      wait_base(OVS);
      #1 rx_line_out = msb ? d[7 - i] : d[i];
    end
    wait_base(OVS);
    #1 rx_line_out = 1'b1;
    wait_base(2 * OVS);
  endtask : send
  // Returns mid stop bit to catch a back-to-back start
  task automatic recv(output logic [7:0] d);
    while (tx_line_in !== 1'b0)
      @(posedge clk_in);
    wait_base(OVS / 2);
    for (int i = 0; i < 8; i++)
    begin
      wait_base(OVS);
      d[i] = tx_line_in;
    end
    wait_base(OVS);
  endtask : recv
endmodule : remote_node
`default_nettype wire

// ---- tb/uart_core_tb.sv ----
// Self-checking bench for uart_core with a remote serial node.
// Assumes package, design, node and checker compile first.
`timescale 1ns/10ps
`default_nettype none
module uart_core_tb;
  localparam int OVS = 4;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        base_fall_in = 1'b0;
  logic        msb_first_in = 1'b0;
  logic [15:0] cpu_addr_in = 16'h0000;
  logic        cpu_wr_in = 1'b0;
  logic        cpu_bit_wr_in = 1'b0;
  logic [2:0]  cpu_bit_idx_in = 3'h0;
  logic        cpu_bit_val_in = 1'b0;
  logic [7:0]  cpu_wdata_in = 8'h00;
  logic        cpu_rd_in = 1'b0;
  logic        serial_in_pin_in, serial_out_pin_out, rx_done_irq_out;
  logic        transmit_complete_irq_out, rx_error_irq_out;
  logic [7:0]  cpu_rdata_out;
  logic [1:0]  base_cnt = 2'h0;
  logic [7:0]  r1, r2;
  int          errors = 0;
  int          checks_done = 0;
  int          tx_irqs = 0;
  // ------
  // Clocks, design and partner
  // ------
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  // A base falling edge every fourth cycle
  always @(posedge clk_in)
  begin
    base_cnt <= #1 base_cnt + 2'h1;
    base_fall_in <= #1 base_cnt == 2'h2;
    if (transmit_complete_irq_out === 1'b1)
      tx_irqs++;
  end
  uart_core #(.OVS(OVS)) u_uart_core (
    .*, .ce_in(1'b1), .tx_invert_in(1'b0));
  remote_node #(.OVS(OVS)) u_remote_node (
    .clk_in(clk_in), .base_fall_in(base_fall_in),
    .tx_line_in(serial_out_pin_out), .rx_line_out(serial_in_pin_in));
  // ------
  // Bus and compare tasks
  // ------
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_wr_in = 1'b1;
    @(posedge clk_in);
    #1 cpu_wr_in = 1'b0;
  endtask : wr
  task automatic bw(input logic [2:0] i, input logic v);
    @(posedge clk_in);
    #1 cpu_addr_in = uart_pkg::MODE_OFS;
    cpu_bit_idx_in = i;
    cpu_bit_val_in = v;
    cpu_bit_wr_in = 1'b1;
    @(posedge clk_in);
    #1 cpu_bit_wr_in = 1'b0;
  endtask : bw
  task automatic rc(input logic [15:0] a, input logic [7:0] e,
                    input string n);
    @(posedge clk_in);
    #1 cpu_addr_in = a;
    cpu_rd_in = 1'b1;
    @(posedge clk_in);
    #1 cpu_rd_in = 1'b0;
    chk(n, e, cpu_rdata_out);
  endtask : rc
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    rc(uart_pkg::MODE_OFS, uart_pkg::MODE_RST, "mode reset");
    rc(uart_pkg::RXBUF_OFS, uart_pkg::BUF_RST, "rx buf reset");
    rc(uart_pkg::TXBUF_OFS, uart_pkg::BUF_RST, "tx buf reset");
    chk("idle line", 8'h01, {7'h00, serial_out_pin_out});
    wr(uart_pkg::RXBUF_OFS, uart_pkg::ZERO_BYTE);
    rc(uart_pkg::RXBUF_OFS, uart_pkg::BUF_RST, "rx buf write");
    rc(16'hff40, uart_pkg::ZERO_BYTE, "unmapped");
    $display("Test reset done");
  endtask : t_reset
  task automatic t_tx();
    bw(3'h7, 1'b1);
    bw(3'h6, 1'b1);
    rc(uart_pkg::MODE_OFS, 8'hc1, "bit writes");
    wr(uart_pkg::MODE_OFS, 8'hc4);
    repeat (8) @(posedge clk_in);
    fork
      begin
        u_remote_node.recv(r1);
        u_remote_node.recv(r2);
      end
      begin
        wr(uart_pkg::TXBUF_OFS, 8'ha5);
        repeat (8) @(posedge clk_in);
        rc(uart_pkg::TXST_OFS, 8'h01, "tx status");
        wr(uart_pkg::MODE_OFS, 8'hc4);
        wr(uart_pkg::TXBUF_OFS, 8'h3c);
      end
    join
    repeat (24) @(posedge clk_in);
    chk("frame 1", 8'ha5, r1);
    chk("frame 2", 8'h3c, r2);
    chk("tx irqs", 8'h02, tx_irqs[7:0]);
    chk("idle line", 8'h01, {7'h00, serial_out_pin_out});
    $display("Test transmit done");
  endtask : t_tx
  task automatic t_rx();
    wr(uart_pkg::MODE_OFS, 8'ha0);
    repeat (8) @(posedge clk_in);
    u_remote_node.send(8'hd5, 7, 1'b0);
    u_remote_node.send(8'h0f, 7, 1'b0);
    rc(uart_pkg::RXBUF_OFS, 8'h55, "lsb 7-bit kept");
    rc(uart_pkg::ERR_OFS, 8'h01, "overrun flag");
    msb_first_in = 1'b1;
    u_remote_node.send(8'hab, 7, 1'b1);
    rc(uart_pkg::RXBUF_OFS, 8'haa, "msb 7-bit");
    $display("Test receive done");
  endtask : t_rx
  task automatic t_power();
    wr(uart_pkg::MODE_OFS, 8'hc4);
    repeat (8) @(posedge clk_in);
    wr(uart_pkg::TXBUF_OFS, 8'h00);
    repeat (24) @(posedge clk_in);
    chk("frame low", 8'h00, {7'h00, serial_out_pin_out});
    bw(3'h7, 1'b0);
    repeat (4) @(posedge clk_in);
    chk("line off", 8'h01, {7'h00, serial_out_pin_out});
    rc(uart_pkg::RXBUF_OFS, uart_pkg::BUF_RST, "rx buf off");
    rc(uart_pkg::TXBUF_OFS, uart_pkg::ZERO_BYTE, "tx buf kept");
    $display("Test power done");
  endtask : t_power
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_power();
    end_sim();
  end
  // 10000 cycles is far past a clean run
  initial
  begin
    #40000;
    errors++;
    $display("Error watchdog: expected finish, seen hang");
    end_sim();
  end
endmodule : uart_core_tb
bind uart_core uart_core_asserts #(.OVS(OVS)) u_uart_core_asserts (.*);
`default_nettype wire
